// [rtl/rbs_host.sv]
// Purpose: Host controller driving a byte-wide clock/SRAM supervisor by its pins
// Assumes: 10 MHz clock; device strobes active low; SRAM address lines driven elsewhere
// Notes:   One access at a time; read data passes a three-stage synchroniser
`timescale 1ns/1ps
module rbs_host (
  input  wire logic                        i_sys_clk,
  input  wire logic                        i_rst_n,
  // User command port
  input  wire logic                        i_req,
  input  wire logic                        i_wr,
  input  wire logic                        i_target,
  input  wire logic [rbs_pkg::ADDR_W-1:0]  i_reg_addr,
  input  wire logic                        i_bank,
  input  wire logic [rbs_pkg::DATA_W-1:0]  i_wdata,
  output logic                             o_ready,
  output logic                             o_rvalid,
  output logic [rbs_pkg::DATA_W-1:0]       o_rdata,
  // Device pins
  input  wire logic                        i_powerfail,
  output logic [rbs_pkg::ADDR_W-1:0]       o_reg_addr,
  output logic                             o_chip_en_n,
  output logic                             o_out_en_n,
  output logic                             o_wr_en_n,
  output logic                             o_sram_request_n,
  output logic                             o_bank_sel,
  input  wire logic [rbs_pkg::DATA_W-1:0]  i_data_bus,
  output logic [rbs_pkg::DATA_W-1:0]       o_data_bus,
  output logic                             o_data_bus_oe
);
  rbs_sync_if sif ();

  rbs_sync u_sync (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .sif       (sif)
  );

  assign sif.raw = {i_powerfail, i_data_bus};

  logic                        pf;
  logic [rbs_pkg::DATA_W-1:0]  din;
  assign pf  = sif.stable[8];
  assign din = sif.stable[7:0];

  rbs_pkg::rbs_state_e         state;
  rbs_pkg::rbs_state_e         next_state;
  logic [rbs_pkg::CNT_W-1:0]   cnt;
  logic [rbs_pkg::CNT_W-1:0]   next_cnt;
  logic                        is_wr;
  logic                        next_is_wr;
  logic                        tgt;
  logic                        next_tgt;
  logic [rbs_pkg::ADDR_W-1:0]  addr;
  logic [rbs_pkg::ADDR_W-1:0]  next_addr;
  logic                        bank;
  logic                        next_bank;
  logic [rbs_pkg::DATA_W-1:0]  wdata;
  logic [rbs_pkg::DATA_W-1:0]  next_wdata;
  logic                        ce_n;
  logic                        next_ce_n;
  logic                        oe_n;
  logic                        next_oe_n;
  logic                        we_n;
  logic                        next_we_n;
  logic                        ex_n;
  logic                        next_ex_n;
  logic                        doe;
  logic                        next_doe;
  logic [rbs_pkg::DATA_W-1:0]  rdata;
  logic [rbs_pkg::DATA_W-1:0]  next_rdata;
  logic                        rvalid;
  logic                        next_rvalid;

  // Requests wait while power is failing; the device would ignore them anyway
  assign o_ready = (state == rbs_pkg::RBS_IDLE) && !pf;

  always_comb begin
    next_state  = state;
    next_cnt    = cnt;
    next_is_wr  = is_wr;
    next_tgt    = tgt;
    next_addr   = addr;
    next_bank   = bank;
    next_wdata  = wdata;
    next_ce_n   = 1'b1;
    next_oe_n   = 1'b1;
    next_we_n   = 1'b1;
    next_ex_n   = 1'b1;
    next_doe    = 1'b0;
    next_rdata  = rdata;
    next_rvalid = 1'b0;
    case (state)
      rbs_pkg::RBS_IDLE: begin
        if (i_req && o_ready) begin
          next_is_wr = i_wr;
          next_tgt   = i_target;
          next_addr  = i_reg_addr;
          next_bank  = i_bank;
          next_wdata = i_wdata;
          next_doe   = i_wr;
          next_state = rbs_pkg::RBS_SETUP;
        end
      end
      rbs_pkg::RBS_SETUP: begin
        // Address and data settle one cycle before any strobe falls
        next_doe   = is_wr;
        next_ce_n  = tgt != rbs_pkg::TARGET_REG;
        next_ex_n  = tgt != rbs_pkg::TARGET_SRAM;
        next_we_n  = !is_wr;
        next_oe_n  = is_wr;
        next_cnt   = is_wr ? rbs_pkg::WR_LOAD : rbs_pkg::RD_LOAD;
        next_state = rbs_pkg::RBS_ACT;
        if (pf) begin
          next_ce_n  = 1'b1;
          next_ex_n  = 1'b1;
          next_we_n  = 1'b1;
          next_oe_n  = 1'b1;
          next_cnt   = rbs_pkg::HIZ_LOAD;
          next_state = rbs_pkg::RBS_END;
        end
      end
      rbs_pkg::RBS_ACT: begin
        next_doe  = is_wr;
        next_ce_n = ce_n;
        next_ex_n = ex_n;
        next_we_n = we_n;
        next_oe_n = oe_n;
        if (cnt != '0) begin
          next_cnt = cnt - 1'b1;
        end else begin
          // Both strobes rise together; write data stays on the bus two more cycles
          next_ce_n  = 1'b1;
          next_ex_n  = 1'b1;
          next_we_n  = 1'b1;
          next_oe_n  = 1'b1;
          next_cnt   = rbs_pkg::HIZ_LOAD;
          next_state = rbs_pkg::RBS_END;
          if (!is_wr) begin
            next_rdata  = din;
            next_rvalid = 1'b1;
          end
        end
        if (pf) begin
          next_ce_n  = 1'b1;
          next_ex_n  = 1'b1;
          next_we_n  = 1'b1;
          next_oe_n  = 1'b1;
          next_rvalid = 1'b0;
          next_cnt   = rbs_pkg::HIZ_LOAD;
          next_state = rbs_pkg::RBS_END;
        end
      end
      rbs_pkg::RBS_END: begin
        // Write data held past the rising edge; read waits out device float time
        next_doe = is_wr && (cnt == rbs_pkg::HIZ_LOAD);
        if (cnt != '0) begin
          next_cnt = cnt - 1'b1;
        end else begin
          next_state = rbs_pkg::RBS_IDLE;
        end
      end
      default: next_state = rbs_pkg::RBS_IDLE;
    endcase
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      state  <= rbs_pkg::RBS_IDLE;
      cnt    <= 4'h0;
      is_wr  <= 1'b0;
      tgt    <= 1'b0;
      addr   <= 4'h0;
      bank   <= 1'b0;
      wdata  <= 8'h00;
      ce_n   <= 1'b1;
      oe_n   <= 1'b1;
      we_n   <= 1'b1;
      ex_n   <= 1'b1;
      doe    <= 1'b0;
      rdata  <= 8'h00;
      rvalid <= 1'b0;
    end else begin
      state  <= next_state;
      cnt    <= next_cnt;
      is_wr  <= next_is_wr;
      tgt    <= next_tgt;
      addr   <= next_addr;
      bank   <= next_bank;
      wdata  <= next_wdata;
      ce_n   <= next_ce_n;
      oe_n   <= next_oe_n;
      we_n   <= next_we_n;
      ex_n   <= next_ex_n;
      doe    <= next_doe;
      rdata  <= next_rdata;
      rvalid <= next_rvalid;
    end
  end

  assign o_reg_addr       = addr;
  assign o_bank_sel       = bank;
  assign o_chip_en_n      = ce_n;
  assign o_out_en_n       = oe_n;
  assign o_wr_en_n        = we_n;
  assign o_sram_request_n = ex_n;
  assign o_data_bus       = wdata;
  assign o_data_bus_oe    = doe;
  assign o_rdata          = rdata;
  assign o_rvalid         = rvalid;

  property p_no_dual_select;
    @(posedge i_sys_clk) disable iff (!i_rst_n) !(!o_chip_en_n && !o_sram_request_n);
  endproperty
  a_no_dual_select: assert property (p_no_dual_select) else $error("both enables low");

  property p_oe_high_in_write;
    @(posedge i_sys_clk) disable iff (!i_rst_n) !o_wr_en_n |-> o_out_en_n && o_data_bus_oe;
  endproperty
  a_oe_high_in_write: assert property (p_oe_high_in_write) else $error("output enable low in write");

  property p_no_contention;
    @(posedge i_sys_clk) disable iff (!i_rst_n) !o_out_en_n |-> !o_data_bus_oe && o_wr_en_n;
  endproperty
  a_no_contention: assert property (p_no_contention) else $error("host drives bus during read");

  property p_addr_hold;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      $fell(o_wr_en_n) |-> $stable(o_reg_addr) ##1 ($stable(o_reg_addr) && $stable(o_bank_sel));
  endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("address moved during write");

  property p_data_around_end;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      $rose(o_wr_en_n) |-> $past(o_data_bus_oe) && o_data_bus_oe && $stable(o_data_bus);
  endproperty
  a_data_around_end: assert property (p_data_around_end) else $error("write data not held");

  property p_write_pulse;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      $fell(o_wr_en_n) |-> ##1 $rose(o_wr_en_n) && o_chip_en_n && o_sram_request_n;
  endproperty
  a_write_pulse: assert property (p_write_pulse) else $error("write pulse length wrong");

  property p_read_result;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      ($fell(o_out_en_n) && !pf ##1 !pf [*4]) |-> ##1 o_rvalid;
  endproperty
  a_read_result: assert property (p_read_result) else $error("read data late");

  property p_powerfail_release;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      pf |-> !o_ready ##1 (o_chip_en_n && o_sram_request_n && o_wr_en_n && o_out_en_n);
  endproperty
  a_powerfail_release: assert property (p_powerfail_release) else $error("strobes during power fail");

  property p_target_enable;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      (!o_chip_en_n |-> tgt == rbs_pkg::TARGET_REG) and (!o_sram_request_n |-> tgt == rbs_pkg::TARGET_SRAM);
  endproperty
  a_target_enable: assert property (p_target_enable) else $error("wrong enable for target");
endmodule // rbs_host

// [rtl/rbs_pkg.sv]
// Purpose: Constants for the host side of a byte-wide clock/SRAM supervisor port
// Assumes: 10 MHz system clock
// Notes:   Times in ns, cycle counts derived from them
package rbs_pkg;
  localparam int unsigned CLK_PERIOD_NS   = 100;
  localparam int unsigned T_ACCESS_NS     = 85;   // Address/enable to data valid
  localparam int unsigned T_WR_PULSE_NS   = 60;   // Widest of the two strobe minimums
  localparam int unsigned T_DATA_SETUP_NS = 30;
  localparam int unsigned T_HIZ_NS        = 25;   // Output float after strobe release
  localparam int unsigned SYNC_STAGES     = 3;
  localparam int unsigned ADDR_W          = 4;
  localparam int unsigned DATA_W          = 8;
  localparam int unsigned CNT_W           = 4;

  function automatic int unsigned ceil_cyc(input int unsigned t_ns);
    ceil_cyc = (t_ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    if (ceil_cyc == 0) ceil_cyc = 1;
  endfunction

  localparam int unsigned ACCESS_CYC  = ceil_cyc(T_ACCESS_NS);
  localparam int unsigned WR_CYC      = ceil_cyc(T_WR_PULSE_NS) > ceil_cyc(T_DATA_SETUP_NS) ?
                                        ceil_cyc(T_WR_PULSE_NS) : ceil_cyc(T_DATA_SETUP_NS);
  localparam int unsigned RD_WAIT_CYC = ACCESS_CYC + SYNC_STAGES + 1;
  localparam int unsigned HIZ_CYC     = ceil_cyc(T_HIZ_NS);

  localparam logic [CNT_W-1:0] WR_LOAD  = CNT_W'(WR_CYC - 1);
  localparam logic [CNT_W-1:0] RD_LOAD  = CNT_W'(RD_WAIT_CYC - 1);
  localparam logic [CNT_W-1:0] HIZ_LOAD = CNT_W'(HIZ_CYC - 1);

  localparam logic TARGET_REG  = 1'b0;
  localparam logic TARGET_SRAM = 1'b1;

  typedef enum logic [1:0] {
    RBS_IDLE  = 2'b00,
    RBS_SETUP = 2'b01,
    RBS_ACT   = 2'b10,
    RBS_END   = 2'b11
  } rbs_state_e;
endpackage

// [rtl/rbs_sync_if.sv]
// Purpose: Carries raw pin levels to the synchroniser and stable levels back
// Assumes: Single clock domain on the stable side
// Notes:   Bit 8 is the power-fail level, bits 7:0 the data bus
`timescale 1ns/1ps
interface rbs_sync_if;
  logic [8:0] raw;
  logic [8:0] stable;
  modport owner (output raw, input stable);
  modport sync  (input raw, output stable);
endinterface

// [rtl/rbs_sync.sv]
// Purpose: Three-stage synchroniser with agreement filter
// Assumes: Inputs asynchronous to i_sys_clk
// Notes:   Stage one feeds only stage two
`timescale 1ns/1ps
module rbs_sync (
  input  wire logic  i_sys_clk,
  input  wire logic  i_rst_n,
  rbs_sync_if.sync   sif
);
  logic [8:0] s1;
  logic [8:0] s2;
  logic [8:0] s3;
  logic [8:0] stable;
  logic [8:0] next_stable;

  // A level counts only once the last two stages agree
  always_comb begin
    next_stable = stable;
    for (int i = 0; i < 9; i++) begin
      if (s2[i] == s3[i]) next_stable[i] = s3[i];
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      s1     <= 9'h000;
      s2     <= 9'h000;
      s3     <= 9'h000;
      stable <= 9'h000;
    end else begin
      s1     <= sif.raw;
      s2     <= s1;
      s3     <= s2;
      stable <= next_stable;
    end
  end

  assign sif.stable = stable;
endmodule // rbs_sync

// [verif/rbs_dev_model.sv]
// Purpose: Behavioural clock/SRAM supervisor facing the host controller
// Assumes: SRAM word picked by the register address lines
// Notes:   No pull-ups, so a released bus shows the inverse of the last byte the model drove
`timescale 1ns/1ps
module rbs_dev_model (
  input  wire logic       i_powerfail,
  input  wire logic [3:0] i_reg_addr,
  input  wire logic       i_chip_en_n,
  input  wire logic       i_out_en_n,
  input  wire logic       i_wr_en_n,
  input  wire logic       i_sram_request_n,
  input  wire logic       i_bank_sel,
  input  wire logic [7:0] i_data_bus,
  output logic      [7:0] o_data_bus,
  output logic            o_data_bus_oe,
  output logic            o_sram_bank0_select_n,
  output logic            o_sram_bank1_select_n
);
  logic [7:0] regs [16];
  logic [7:0] sram [2][16];
  logic [7:0] last = 8'h00;
  logic       reg_wr;
  logic       sram_wr;
  logic       reg_rd;
  logic       sram_rd;

  assign o_sram_bank0_select_n = i_powerfail | i_sram_request_n | i_bank_sel;
  assign o_sram_bank1_select_n = i_powerfail | i_sram_request_n | ~i_bank_sel;
  assign reg_wr  = !i_powerfail && !i_chip_en_n && !i_wr_en_n;
  assign sram_wr = !i_powerfail && i_chip_en_n && !i_sram_request_n && !i_wr_en_n;
  assign reg_rd  = !i_powerfail && !i_chip_en_n && !i_out_en_n && i_wr_en_n;
  assign sram_rd = !i_powerfail && i_chip_en_n && !i_sram_request_n && !i_out_en_n && i_wr_en_n;
  assign o_data_bus_oe = reg_rd | sram_rd;

  // Stores land on the first rising strobe, which ends the write
  always @(negedge reg_wr) regs[i_reg_addr] = i_data_bus;
  always @(negedge sram_wr) sram[i_bank_sel][i_reg_addr] = i_data_bus;

  always @* begin
    if (reg_rd)
      o_data_bus = regs[i_reg_addr];
    else if (sram_rd)
      o_data_bus = sram[i_bank_sel][i_reg_addr];
    else
      o_data_bus = ~last;
  end
  always @* if (o_data_bus_oe) last = o_data_bus;
endmodule // rbs_dev_model

// [verif/tb_rtc_byte_bus_sram_bank_select.sv]
// Purpose: Self-checking bench for the host controller against a device model
// Assumes: Inputs change on the falling clock edge
// Notes:   Bus pins watched every cycle for enable clashes and write framing
`timescale 1ns/1ps
module tb_rtc_byte_bus_sram_bank_select;
  logic       i_sys_clk = 1'b0;
  logic       i_rst_n = 1'b0;
  logic       i_req = 1'b0;
  logic       i_wr = 1'b0;
  logic       i_target = 1'b0;
  logic [3:0] i_reg_addr = 4'h0;
  logic       i_bank = 1'b0;
  logic [7:0] i_wdata = 8'h00;
  logic       i_powerfail = 1'b0;
  logic       o_ready, o_rvalid, o_chip_en_n, o_out_en_n, o_wr_en_n, o_sram_request_n, o_bank_sel, o_data_bus_oe;
  logic [7:0] o_rdata, o_data_bus, dev_data, bus;
  logic [3:0] o_reg_addr, prev_addr;
  logic       dev_oe, bank0_n, bank1_n, prev_wr_low;
  int         error_cnt = 0;
  int         checked = 0;

  always #50 i_sys_clk = ~i_sys_clk;
  assign bus = o_data_bus_oe ? o_data_bus : dev_data;

  rbs_host u_dut (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_req(i_req), .i_wr(i_wr), .i_target(i_target),
    .i_reg_addr(i_reg_addr), .i_bank(i_bank), .i_wdata(i_wdata), .o_ready(o_ready), .o_rvalid(o_rvalid),
    .o_rdata(o_rdata), .i_powerfail(i_powerfail), .o_reg_addr(o_reg_addr), .o_chip_en_n(o_chip_en_n),
    .o_out_en_n(o_out_en_n), .o_wr_en_n(o_wr_en_n), .o_sram_request_n(o_sram_request_n), .o_bank_sel(o_bank_sel),
    .i_data_bus(bus), .o_data_bus(o_data_bus), .o_data_bus_oe(o_data_bus_oe));

  rbs_dev_model u_dev (.i_powerfail(i_powerfail), .i_reg_addr(o_reg_addr), .i_chip_en_n(o_chip_en_n),
    .i_out_en_n(o_out_en_n), .i_wr_en_n(o_wr_en_n), .i_sram_request_n(o_sram_request_n), .i_bank_sel(o_bank_sel),
    .i_data_bus(bus), .o_data_bus(dev_data), .o_data_bus_oe(dev_oe), .o_sram_bank0_select_n(bank0_n),
    .o_sram_bank1_select_n(bank1_n));

  task automatic check(input logic ok, input string msg);
    checked++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("ERROR at %0t ns: %s", $time, msg);
    end
  endtask

  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // One command; waits for ready, then always spends 12 cycles watching for read data
  task automatic access(input logic wr, input logic tgt, input logic [3:0] a, input logic bk,
                        input logic [7:0] d, output logic [7:0] q, output logic got);
    int n;
    got = 1'b0;
    q = 8'h00;
    n = 0;
    @(negedge i_sys_clk);
    while (o_ready !== 1'b1 && n < 20) begin
      @(negedge i_sys_clk);
      n++;
    end
    i_req = 1'b1; i_wr = wr; i_target = tgt; i_reg_addr = a; i_bank = bk; i_wdata = d;
    @(negedge i_sys_clk);
    i_req = 1'b0;
    for (n = 0; n < 12; n++) begin
      if (o_rvalid === 1'b1) begin
        got = 1'b1;
        q = o_rdata;
      end
      @(negedge i_sys_clk);
    end
  endtask

  // Writes to every address in turn, one access call each, then read each back
  task automatic t_regs();
    logic [7:0] q;
    logic       g;
    for (int a = 0; a < 16; a++) access(1'b1, 1'b0, 4'(a), 1'b0, {4'(a), ~4'(a)}, q, g);
    for (int a = 0; a < 16; a++) begin
      access(1'b0, 1'b0, 4'(a), 1'b0, 8'h00, q, g);
      check(g === 1'b1 && q === {4'(a), ~4'(a)}, "register read mismatch");
    end
  endtask

  // Two banks at one address must stay apart and leave the register alone
  task automatic t_sram();
    logic [7:0] q;
    logic       g;
    access(1'b1, 1'b1, 4'h3, 1'b0, 8'hA5, q, g);
    access(1'b1, 1'b1, 4'h3, 1'b1, 8'h5A, q, g);
    access(1'b0, 1'b1, 4'h3, 1'b0, 8'h00, q, g);
    check(g === 1'b1 && q === 8'hA5, "bank0 read mismatch");
    access(1'b0, 1'b1, 4'h3, 1'b1, 8'h00, q, g);
    check(g === 1'b1 && q === 8'h5A, "bank1 read mismatch");
    access(1'b0, 1'b0, 4'h3, 1'b0, 8'h00, q, g);
    check(g === 1'b1 && q === 8'h3C, "register hit by sram write");
  endtask

  // Requests during power-fail are refused and change nothing
  task automatic t_pf();
    logic [7:0] q;
    logic       g;
    i_powerfail = 1'b1;
    repeat (5) @(negedge i_sys_clk);
    check(o_ready === 1'b0, "ready during power-fail");
    access(1'b1, 1'b0, 4'h0, 1'b0, 8'h77, q, g);
    check(o_chip_en_n === 1'b1 && bank0_n === 1'b1 && bank1_n === 1'b1, "enables low in power-fail");
    i_powerfail = 1'b0;
    repeat (6) @(negedge i_sys_clk);
    access(1'b0, 1'b0, 4'h0, 1'b0, 8'h00, q, g);
    check(g === 1'b1 && q === 8'h0F, "write took effect in power-fail");
  endtask

  // Power-fail in mid read aborts with no data and raised strobes
  task automatic t_pf_mid();
    logic seen;
    seen = 1'b0;
    @(negedge i_sys_clk);
    i_req = 1'b1; i_wr = 1'b0; i_target = 1'b0; i_reg_addr = 4'h5;
    @(negedge i_sys_clk);
    i_req = 1'b0;
    @(negedge i_sys_clk);
    i_powerfail = 1'b1;
    repeat (12) begin
      @(negedge i_sys_clk);
      if (o_rvalid === 1'b1) seen = 1'b1;
    end
    check(seen === 1'b0 && o_chip_en_n === 1'b1 && o_out_en_n === 1'b1, "read not aborted");
    i_powerfail = 1'b0;
    repeat (6) @(negedge i_sys_clk);
  endtask

  // Pin watch: enable clash, read strobe in a write, address and data held to the write end
  always @(negedge i_sys_clk) begin
    if (i_rst_n) begin
      check(!(o_chip_en_n === 1'b0 && o_sram_request_n === 1'b0), "both enables low");
      check(!(o_out_en_n === 1'b0 && (o_data_bus_oe !== 1'b0 || o_wr_en_n !== 1'b1)), "read strobe in write");
      check(!(dev_oe === 1'b1 && o_data_bus_oe !== 1'b0), "bus driven from both ends");
      if (prev_wr_low && o_wr_en_n === 1'b1)
        check(o_reg_addr === prev_addr && o_data_bus_oe === 1'b1, "address or data dropped at write end");
    end
    prev_wr_low = (o_wr_en_n === 1'b0);
    prev_addr = o_reg_addr;
  end

  // Tests need about 600 cycles; the limit leaves wide margin
  initial begin
    repeat (6000) @(posedge i_sys_clk);
    error_cnt++;
    $display("ERROR at %0t ns: watchdog expired", $time);
    summarize();
  end

  initial begin
    repeat (6) @(negedge i_sys_clk);
    i_rst_n = 1'b1;
    t_regs();
    t_sram();
    t_pf();
    t_pf_mid();
    summarize();
  end
endmodule // tb_rtc_byte_bus_sram_bank_select
